// ==== hdl/pmc_defines.vh ====
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

// ==========================================================
// Register indices and byte addresses
`define PMC_IDX_CFG_FIRST    16'h0514
`define PMC_IDX_CFG_SECOND   16'h0516
`define PMC_ADDR_SHIFT       2
`define PMC_ADDR_W           16
`define PMC_DATA_W           32
`define PMC_REG_W            16

// ==========================================================
// First register fields
`define PMC_B_AS_EN          7
`define PMC_B_PTP_EN         6
`define PMC_B_DET_L2         5
`define PMC_B_DET_IP4        4
`define PMC_B_DET_IP6        3
`define PMC_B_P2P            2
`define PMC_B_MASTER         1
`define PMC_B_ONE_STEP       0
`define PMC_RST_FIRST        16'h0039
`define PMC_MASK_FIRST       16'h00FF

// ==========================================================
// Second register fields
`define PMC_B_UNICAST        12
`define PMC_B_ALT_MASTER     11
`define PMC_B_ALL_PRIO       10
`define PMC_B_SYNC_ASSOC     9
`define PMC_RST_SECOND       16'h1000
`define PMC_MASK_SECOND      16'h1E00

// ==========================================================
// Frame encapsulation codes
`define PMC_ENC_W            2
`define PMC_ENC_NONE         2'h0
`define PMC_ENC_L2           2'h1
`define PMC_ENC_IP4          2'h2
`define PMC_ENC_IP6          2'h3

// ==========================================================
// Message types and ports
`define PMC_TYPE_W           4
`define PMC_MSG_SYNC         4'h0
`define PMC_MSG_DELAY_REQ    4'h1
`define PMC_MSG_FOLLOW_UP    4'h8
`define PMC_EVENT_LIMIT      4'h4
`define PMC_UDP_EVENT        16'h013F
`define PMC_UDP_GENERAL      16'h0140

// ==========================================================
// Association table
`define PMC_DOM_W            8
`define PMC_SEQ_W            16
`define PMC_SRC_W            80
`define PMC_TAG_W            104
`define PMC_IDX_W            4
`define PMC_DEPTH            16

`endif

// ==== hdl/pmc_assoc_mem.v ====
`timescale 1ns/1ps
`include "pmc_defines.vh"

module pmc_assoc_mem (
  // Clock
  input  wire                    clk,
  input  wire                    ce,
  // Write port
  input  wire                    wrEn,
  input  wire [`PMC_IDX_W-1:0]   wrIdx,
  input  wire [`PMC_TAG_W-1:0]   wrData,
  // Read port
  input  wire [`PMC_IDX_W-1:0]   rdIdx,
  output reg  [`PMC_TAG_W-1:0]   rdData
);

  reg [`PMC_TAG_W-1:0] mem [0:`PMC_DEPTH-1];

  always @(posedge clk) begin
    if (ce) begin
      if (wrEn) begin
        mem[wrIdx] <= wrData;
      end
      rdData <= mem[rdIdx];
    end
  end

endmodule // pmc_assoc_mem

// ==== hdl/pmc_ptp_msg_config.v ====
// Behaviour
// - 802.1AS enable needs PTP enable too
// - AS mode: all PTP except unicast lookup frames to host, unmodified
// - PTP mode classifies messages by type
// - PTP mode allows header rewrite, timestamps
// - PTP enable turns on PTP clock
// - PTP mode uses timestamp tail tag
// - Detect 802.3 PTP only when enabled
// - Detect IPv4/UDP PTP only when enabled
// - Detect IPv6/UDP PTP only when enabled
// - Select bit picks P2P or E2E
// - Select bit picks host master or slave
// - Select bit picks one or two step
// - Unicast on ports 319/320 uses lookup
// - Unicast disabled: only multicast PTP recognised
// - Alternate master: forward Sync/Delay_Req to non-host; here only in the same domain
// - No alternate master: drop at host
// - Queue bit: all or event to top
// - Follow_up to host only on match
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "pmc_defines.vh"

module pmc_ptp_msg_config (
  // Clock and reset
  input  wire                    clk,
  input  wire                    reset_n,
  input  wire                    ce,
  // APB slave
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`PMC_ADDR_W-1:0]  paddr,
  input  wire [`PMC_DATA_W-1:0]  pwdata,
  input  wire [3:0]              pstrb,
  output reg                     pready,
  output reg  [`PMC_DATA_W-1:0]  prdata,
  output reg                     pslverr,
  // Parsed frame descriptor
  input  wire                    frmValid,
  input  wire [`PMC_ENC_W-1:0]   frmEncap,
  input  wire                    frmReservedAddr,
  input  wire [15:0]             frmUdpPort,
  input  wire [`PMC_TYPE_W-1:0]  frmMsgType,
  input  wire                    frmFromHost,
  input  wire                    frmSameDomain,
  input  wire                    frmActiveMaster,
  input  wire [`PMC_DOM_W-1:0]   frmDomain,
  input  wire [`PMC_SEQ_W-1:0]   frmSeqId,
  input  wire [`PMC_SRC_W-1:0]   frmSrcPortId,
  // Global mode outputs
  output reg                     ptpClockEn,
  output reg                     tailTagPtp,
  output reg                     hdrModifyEn,
  output reg                     tsInsertEn,
  output reg                     tcPeerToPeer,
  output reg                     hostMaster,
  output reg                     oneStep,
  // Per-frame decision
  output reg                     resValid,
  output reg                     resIsPtp,
  output reg                     resUseLookup,
  output reg                     resToHost,
  output reg                     resToNonHost,
  output reg                     resHighQueue,
  output reg                     resModify
);

  // ==========================================================
  // Helpers
  function regHit;
    input [`PMC_ADDR_W-1:0] addr;
    input [`PMC_ADDR_W-1:0] idx;
    begin
      regHit = (addr == (idx << `PMC_ADDR_SHIFT));
    end
  endfunction

  function [`PMC_REG_W-1:0] laneMerge;
    input [`PMC_REG_W-1:0] oldVal;
    input [`PMC_DATA_W-1:0] wData;
    input [3:0]             strb;
    input [`PMC_REG_W-1:0] mask;
    reg   [`PMC_REG_W-1:0] merged;
    begin
      merged[7:0]  = strb[0] ? wData[7:0]  : oldVal[7:0];
      merged[15:8] = strb[1] ? wData[15:8] : oldVal[15:8];
      laneMerge    = merged & mask;
    end
  endfunction

  function encapEnabled;
    input [`PMC_ENC_W-1:0] encap;
    input                  l2En;
    input                  ip4En;
    input                  ip6En;
    begin
      case (encap)
        `PMC_ENC_L2:  encapEnabled = l2En;
        `PMC_ENC_IP4: encapEnabled = ip4En;
        `PMC_ENC_IP6: encapEnabled = ip6En;
        default:      encapEnabled = 1'b0;
      endcase
    end
  endfunction

  function typeIsSync;
    input [`PMC_TYPE_W-1:0] msgType;
    begin
      typeIsSync = (msgType == `PMC_MSG_SYNC);
    end
  endfunction

  function typeIsSyncReq;
    input [`PMC_TYPE_W-1:0] msgType;
    begin
      typeIsSyncReq = typeIsSync(msgType) | (msgType == `PMC_MSG_DELAY_REQ);
    end
  endfunction

  function typeIsFollow;
    input [`PMC_TYPE_W-1:0] msgType;
    begin
      typeIsFollow = (msgType == `PMC_MSG_FOLLOW_UP);
    end
  endfunction

  function typeIsEvent;
    input [`PMC_TYPE_W-1:0] msgType;
    begin
      typeIsEvent = (msgType < `PMC_EVENT_LIMIT);
    end
  endfunction

  // ==========================================================
  // Registers
  reg  [`PMC_REG_W-1:0] cfgFirst_q;
  reg  [`PMC_REG_W-1:0] cfgSecond_q;

  wire hitFirst  = regHit(paddr, `PMC_IDX_CFG_FIRST);
  wire hitSecond = regHit(paddr, `PMC_IDX_CFG_SECOND);
  wire setupAcc  = psel & penable & ~pready;
  wire doneAcc   = psel & penable & pready;

  reg  [`PMC_REG_W-1:0]  cfgFirst_d;
  reg  [`PMC_REG_W-1:0]  cfgSecond_d;
  reg  [`PMC_DATA_W-1:0] readWord;

  // Write merge and read select
  always @* begin
    cfgFirst_d  = cfgFirst_q;
    cfgSecond_d = cfgSecond_q;
    readWord    = {`PMC_DATA_W{1'b0}};
    if (doneAcc & pwrite & hitFirst) begin
      cfgFirst_d = laneMerge(cfgFirst_q, pwdata, pstrb, `PMC_MASK_FIRST);
    end
    if (doneAcc & pwrite & hitSecond) begin
      cfgSecond_d = laneMerge(cfgSecond_q, pwdata, pstrb, `PMC_MASK_SECOND);
    end
    if (hitFirst) begin
      readWord = {{`PMC_DATA_W-`PMC_REG_W{1'b0}}, cfgFirst_q};
    end else if (hitSecond) begin
      readWord = {{`PMC_DATA_W-`PMC_REG_W{1'b0}}, cfgSecond_q};
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      cfgFirst_q  <= `PMC_RST_FIRST;
      cfgSecond_q <= `PMC_RST_SECOND;
      pready      <= 1'b0;
      prdata      <= {`PMC_DATA_W{1'b0}};
      pslverr     <= 1'b0;
    end else if (ce) begin
      pready  <= setupAcc;
      pslverr <= setupAcc & ~(hitFirst | hitSecond);
      if (setupAcc & ~pwrite) begin
        prdata <= readWord;
      end
      cfgFirst_q  <= cfgFirst_d;
      cfgSecond_q <= cfgSecond_d;
    end
  end

  // ==========================================================
  // Decoded configuration
  wire ptpOn     = cfgFirst_q[`PMC_B_PTP_EN];
  wire asOn      = ptpOn & cfgFirst_q[`PMC_B_AS_EN];
  wire detL2     = cfgFirst_q[`PMC_B_DET_L2];
  wire detIp4    = cfgFirst_q[`PMC_B_DET_IP4];
  wire detIp6    = cfgFirst_q[`PMC_B_DET_IP6];
  wire uniOn     = cfgSecond_q[`PMC_B_UNICAST];
  wire altMaster = cfgSecond_q[`PMC_B_ALT_MASTER];
  wire allPrio   = cfgSecond_q[`PMC_B_ALL_PRIO];
  wire syncAssoc = cfgSecond_q[`PMC_B_SYNC_ASSOC];

  // ==========================================================
  // Global mode outputs
  always @(posedge clk) begin
    if (!reset_n) begin
      ptpClockEn   <= 1'b0;
      tailTagPtp   <= 1'b0;
      hdrModifyEn  <= 1'b0;
      tsInsertEn   <= 1'b0;
      tcPeerToPeer <= 1'b0;
      hostMaster   <= 1'b0;
      oneStep      <= 1'b1;
    end else if (ce) begin
      ptpClockEn   <= ptpOn;
      tailTagPtp   <= ptpOn;
      hdrModifyEn  <= ptpOn & ~asOn;
      tsInsertEn   <= ptpOn;
      tcPeerToPeer <= cfgFirst_q[`PMC_B_P2P];
      hostMaster   <= cfgFirst_q[`PMC_B_MASTER];
      oneStep      <= cfgFirst_q[`PMC_B_ONE_STEP];
    end
  end

  // ==========================================================
  // Stage 1: recognition
  wire encapOk = encapEnabled(frmEncap, detL2, detIp4, detIp6);
  wire isUdp   = (frmEncap == `PMC_ENC_IP4) | (frmEncap == `PMC_ENC_IP6);
  wire ptpPort = (frmUdpPort == `PMC_UDP_EVENT) | (frmUdpPort == `PMC_UDP_GENERAL);
  wire uniHit  = uniOn & isUdp & ptpPort & ~frmReservedAddr;
  wire recog   = ptpOn & encapOk & (frmReservedAddr | uniHit);

  reg                    s1Valid_q;
  reg                    s1Ptp_q;
  reg                    s1Uni_q;
  reg                    s1AsOn_q;
  reg [`PMC_TYPE_W-1:0]  s1Type_q;
  reg                    s1FromHost_q;
  reg                    s1SameDom_q;
  reg                    s1ActMaster_q;
  reg [`PMC_TAG_W-1:0]   s1Tag_q;
  reg [`PMC_IDX_W-1:0]   s1Idx_q;
  reg                    s1Valid2_q;
  reg                    s1AltMaster_q;
  reg                    s1AllPrio_q;
  reg                    s1SyncAssoc_q;

  reg [`PMC_DEPTH-1:0]   tagValid_q;
  wire [`PMC_TAG_W-1:0]  memRd;
  wire [`PMC_TAG_W-1:0]  frmTag = {frmDomain, frmSeqId, frmSrcPortId};
  wire [`PMC_IDX_W-1:0]  frmIdx = frmSeqId[`PMC_IDX_W-1:0];
  wire                   syncStore = frmValid & recog & typeIsSync(frmMsgType);

  always @(posedge clk) begin
    if (!reset_n) begin
      s1Valid_q     <= 1'b0;
      s1Ptp_q       <= 1'b0;
      s1Uni_q       <= 1'b0;
      s1AsOn_q      <= 1'b0;
      s1Type_q      <= {`PMC_TYPE_W{1'b0}};
      s1FromHost_q  <= 1'b0;
      s1SameDom_q   <= 1'b0;
      s1ActMaster_q <= 1'b0;
      s1Tag_q       <= {`PMC_TAG_W{1'b0}};
      s1Idx_q       <= {`PMC_IDX_W{1'b0}};
      s1Valid2_q    <= 1'b0;
      s1AltMaster_q <= 1'b0;
      s1AllPrio_q   <= 1'b0;
      s1SyncAssoc_q <= 1'b0;
      tagValid_q    <= {`PMC_DEPTH{1'b0}};
    end else if (ce) begin
      s1Valid_q     <= frmValid;
      s1Ptp_q       <= frmValid & recog;
      s1Uni_q       <= frmValid & recog & uniHit;
      s1AsOn_q      <= asOn;
      s1Type_q      <= frmMsgType;
      s1FromHost_q  <= frmFromHost;
      s1SameDom_q   <= frmSameDomain;
      s1ActMaster_q <= frmActiveMaster;
      s1Tag_q       <= frmTag;
      s1Idx_q       <= frmIdx;
      s1Valid2_q    <= tagValid_q[frmIdx];
      s1AltMaster_q <= altMaster;
      s1AllPrio_q   <= allPrio;
      s1SyncAssoc_q <= syncAssoc;
      if (syncStore) begin
        tagValid_q[frmIdx] <= 1'b1;
      end
    end
  end

  pmc_assoc_mem uAssocMem (
    .clk    (clk),
    .ce     (ce),
    .wrEn   (syncStore),
    .wrIdx  (frmIdx),
    .wrData (frmTag),
    .rdIdx  (frmIdx),
    .rdData (memRd)
  );

  // ==========================================================
  // Stage 2: forwarding decision
  wire isSyncReq  = typeIsSyncReq(s1Type_q);
  wire isFollow   = typeIsFollow(s1Type_q);
  wire assocMatch = s1Valid2_q & (memRd == s1Tag_q);
  wire isEvent    = typeIsEvent(s1Type_q);

  reg toHost;
  reg toNonHost;

  always @* begin
    toHost    = ~s1FromHost_q;
    toNonHost = 1'b1;
    if (s1AsOn_q) begin
      toHost    = 1'b1;
      toNonHost = ~s1FromHost_q;
    end else if (isSyncReq & ~s1FromHost_q & s1ActMaster_q) begin
      if (s1AltMaster_q) begin
        toHost    = 1'b0;
        toNonHost = s1SameDom_q;
      end else begin
        toHost    = 1'b0;
        toNonHost = ~s1SameDom_q;
      end
    end else if (isFollow & s1SyncAssoc_q) begin
      toHost = ~s1FromHost_q & assocMatch;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      resValid     <= 1'b0;
      resIsPtp     <= 1'b0;
      resUseLookup <= 1'b0;
      resToHost    <= 1'b0;
      resToNonHost <= 1'b0;
      resHighQueue <= 1'b0;
      resModify    <= 1'b0;
    end else if (ce) begin
      resValid     <= s1Valid_q;
      resIsPtp     <= s1Ptp_q;
      resUseLookup <= s1Uni_q;
      resToHost    <= s1Ptp_q & ~s1Uni_q & toHost;
      resToNonHost <= s1Ptp_q & ~s1Uni_q & toNonHost;
      resHighQueue <= s1Ptp_q & (s1AllPrio_q | isEvent);
      resModify    <= s1Ptp_q & ~s1AsOn_q;
    end
  end

endmodule // pmc_ptp_msg_config

// ==== testbench/pmc_ptp_msg_config_properties.sv ====
`timescale 1ns/1ps
`include "pmc_defines.vh"
// ==========================================
// Port checker
module pmc_ptp_msg_config_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        ce,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Frame and modes
  input wire logic        frmValid,
  input wire logic        ptpClockEn,
  input wire logic        tailTagPtp,
  input wire logic        tsInsertEn,
  input wire logic        hdrModifyEn,
  input wire logic        resValid,
  input wire logic        resIsPtp,
  input wire logic        resUseLookup,
  input wire logic        resToHost,
  input wire logic        resToNonHost
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire cfgWr = ce && psel && penable && pready && pwrite && pstrb[0] && paddr == 16'h1450;
  property p_clk_en;
    cfgWr |-> ##2 ptpClockEn == $past(pwdata[6], 2);
  endproperty
  a_clk_en: assert property (p_clk_en) else $error("clock enable wrong after write");
  property p_hdr;
    cfgWr |-> ##2 hdrModifyEn == ($past(pwdata[6], 2) && !$past(pwdata[7], 2));
  endproperty
  a_hdr: assert property (p_hdr) else $error("header modify wrong after write");
  property p_tail;
    tailTagPtp == ptpClockEn && tsInsertEn == ptpClockEn;
  endproperty
  a_tail: assert property (p_tail) else $error("tail tag not tied to mode");
  property p_res;
    frmValid && ce |-> ##2 resValid;
  endproperty
  a_res: assert property (p_res) else $error("no decision two cycles after frame");
  property p_ready;
    ce && psel && penable && !pready |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("bus answer late");
  property p_err;
    pslverr |-> pready && paddr != 16'h1450 && paddr != 16'h1458;
  endproperty
  a_err: assert property (p_err) else $error("error on mapped address");
  property p_rsv;
    pready && !pwrite && paddr == 16'h1458 |-> (prdata & 32'hFFFF_E1FF) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
  property p_fwd;
    resValid && !resIsPtp |-> !resToHost && !resToNonHost && !resUseLookup;
  endproperty
  a_fwd: assert property (p_fwd) else $error("forwarding on non PTP frame");
  property p_uni;
    resUseLookup |-> resIsPtp && !resToHost && !resToNonHost;
  endproperty
  a_uni: assert property (p_uni) else $error("unicast not left to lookup");
endmodule // pmc_ptp_msg_config_properties

bind pmc_ptp_msg_config pmc_ptp_msg_config_properties u_chk (.*);

// ==== testbench/pmc_frame_src.sv ====
`timescale 1ns/1ps
// ==========================================
// Network side descriptor source
module pmc_frame_src (
  // Clock
  input  wire logic  clk,
  // Descriptor
  output logic        frmValid,
  output logic [1:0]  frmEncap,
  output logic        frmReservedAddr,
  output logic [15:0] frmUdpPort,
  output logic [3:0]  frmMsgType,
  output logic        frmFromHost,
  output logic        frmSameDomain,
  output logic        frmActiveMaster,
  output logic [7:0]  frmDomain,
  output logic [15:0] frmSeqId,
  output logic [79:0] frmSrcPortId
);
  initial begin
    {frmValid, frmEncap, frmReservedAddr, frmUdpPort, frmMsgType} = '0;
    {frmFromHost, frmSameDomain, frmActiveMaster, frmSeqId} = '0;
    frmDomain = 8'h05;
    frmSrcPortId = 80'h0000_1122_3344_5566_7788;
  end
  task send(input logic [1:0] e, input logic r, input logic [15:0] p, input logic [3:0] t,
            input logic h, input logic s, input logic a, input logic [15:0] q);
    @(posedge clk);
    frmValid <= 1'b1;
    {frmEncap, frmReservedAddr, frmUdpPort, frmMsgType} <= {e, r, p, t};
    {frmFromHost, frmSameDomain, frmActiveMaster, frmSeqId} <= {h, s, a, q};
    @(posedge clk);
    frmValid <= 1'b0;
    // Fields no longer valid: show garbage
    {frmEncap, frmReservedAddr, frmUdpPort, frmMsgType, frmSeqId} <= ~{e, r, p, t, q};
  endtask
endmodule // pmc_frame_src

// ==== testbench/test_pmc_ptp_msg_config.sv ====
`timescale 1ns/1ps
module test_pmc_ptp_msg_config;
  logic clk, reset_n, ce, psel, penable, pwrite, er;
  logic [15:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0] pstrb;
  wire pready, pslverr;
  wire [31:0] prdata;
  wire frmValid, frmReservedAddr, frmFromHost, frmSameDomain, frmActiveMaster;
  wire [1:0] frmEncap;
  wire [15:0] frmUdpPort, frmSeqId;
  wire [3:0] frmMsgType;
  wire [7:0] frmDomain;
  wire [79:0] frmSrcPortId;
  wire ptpClockEn, tailTagPtp, hdrModifyEn, tsInsertEn, tcPeerToPeer, hostMaster, oneStep;
  wire resValid, resIsPtp, resUseLookup, resToHost, resToNonHost, resHighQueue, resModify;
  int mismatches, compares;
  pmc_ptp_msg_config DUT (.*);
  pmc_frame_src src (.*);
  always #5 clk = ~clk;
  // ==========================================
  // Shared tasks
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [32:0] g, input logic [32:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      mismatches++;
      give_verdict;
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge clk);
    #1;
  endtask
  task fr(input logic [1:0] e, input logic r, input logic [15:0] p, input logic [3:0] t,
          input logic h, input logic s, input logic a, input logic [15:0] q, input logic [6:0] x);
    src.send(e, r, p, t, h, s, a, q);
    @(posedge clk);
    #1 chk({resValid, resIsPtp, resUseLookup, resToHost, resToNonHost, resHighQueue, resModify}, x);
  endtask
  // ==========================================
  // Scenarios
  task t_regs;
    #1 chk({ptpClockEn, tcPeerToPeer, hostMaster, oneStep}, 32'h1);
    apb(1'b0, 16'h1450, 32'h0);
    chk({er, rd}, 33'h0_0000_0039);
    apb(1'b0, 16'h1458, 32'h0);
    chk({er, rd}, 33'h0_0000_1000);
    wr(16'h1450, 32'hFFFF_FFFF);
    chk({tcPeerToPeer, hostMaster, oneStep}, 32'h7);
    apb(1'b0, 16'h1450, 32'h0);
    chk(rd, 32'h0000_00FF);
    wr(16'h1450, 32'h0);
    chk({tcPeerToPeer, hostMaster, oneStep}, 32'h0);
    apb(1'b1, 16'h1454, 32'hFFFF_FFFF);
    chk(er, 33'h1);
    wr(16'h1458, 32'hFFFF_FFFF);
    apb(1'b0, 16'h1458, 32'h0);
    chk(rd, 32'h0000_1E00);
    wr(16'h1458, 32'h0000_1000);
  endtask
  task t_as;
    wr(16'h1450, 32'hB9);
    chk({ptpClockEn, hdrModifyEn}, 32'h0);
    fr(2'h1, 1, 16'h0, 4'h0, 1, 0, 0, 16'h1, 7'b1000000);
    wr(16'h1450, 32'hF9);
    chk({ptpClockEn, hdrModifyEn}, 32'h2);
    fr(2'h1, 1, 16'h0, 4'h0, 1, 0, 0, 16'h1, 7'b1101010);
    wr(16'h1450, 32'h79);
    chk({ptpClockEn, hdrModifyEn, tailTagPtp, tsInsertEn}, 32'hF);
    fr(2'h1, 1, 16'h0, 4'h0, 1, 0, 0, 16'h1, 7'b1100111);
    fr(2'h1, 1, 16'h0, 4'h8, 0, 0, 0, 16'h1, 7'b1101101);
  endtask
  task t_detect;
    for (int e = 1; e < 4; e++) begin
      wr(16'h1450, 32'h79 & ~(32'h1 << (6 - e)));
      fr(e[1:0], 1, 16'h13F, 4'h8, 1, 0, 0, 16'h1, 7'b1000000);
      wr(16'h1450, 32'h79);
      fr(e[1:0], 1, 16'h13F, 4'h8, 1, 0, 0, 16'h1, 7'b1100101);
    end
  endtask
  task t_unicast;
    fr(2'h2, 0, 16'h13F, 4'h8, 0, 0, 0, 16'h1, 7'b1110001);
    fr(2'h3, 0, 16'h140, 4'h8, 0, 0, 0, 16'h1, 7'b1110001);
    fr(2'h2, 0, 16'h141, 4'h8, 0, 0, 0, 16'h1, 7'b1000000);
    wr(16'h1458, 32'h0);
    fr(2'h2, 0, 16'h13F, 4'h8, 0, 0, 0, 16'h1, 7'b1000000);
  endtask
  task t_alt;
    for (int t = 0; t < 2; t++) begin
      wr(16'h1458, 32'h800);
      fr(2'h1, 1, 16'h0, t[3:0], 0, 1, 1, 16'h1, 7'b1100111);
      wr(16'h1458, 32'h0);
      fr(2'h1, 1, 16'h0, t[3:0], 0, 1, 1, 16'h1, 7'b1100011);
      fr(2'h1, 1, 16'h0, t[3:0], 0, 0, 1, 16'h1, 7'b1100111);
    end
  endtask
  task t_queue_assoc;
    wr(16'h1458, 32'h400);
    fr(2'h1, 1, 16'h0, 4'h8, 1, 0, 0, 16'h1, 7'b1100111);
    fr(2'h1, 1, 16'h0, 4'hB, 1, 0, 0, 16'h1, 7'b1100111);
    wr(16'h1458, 32'h200);
    fr(2'h1, 1, 16'h0, 4'h0, 0, 0, 0, 16'h5, 7'b1101111);
    fr(2'h1, 1, 16'h0, 4'h8, 0, 0, 0, 16'h5, 7'b1101101);
    fr(2'h1, 1, 16'h0, 4'h8, 0, 0, 0, 16'h6, 7'b1100101);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {clk, reset_n, ce, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    pstrb = 4'hF;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_regs;
    t_as;
    t_detect;
    t_unicast;
    t_alt;
    t_queue_assoc;
    give_verdict;
  end
endmodule // test_pmc_ptp_msg_config
